// ==== rld_dma.sv ====
// Receive descriptor walker and frame data DMA with look-ahead mode
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rld_dma
  import rld_pkg::*;
#(
  parameter int FIFO_DEPTH = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rld_rx_s rx_in,
  output logic mem_req,
  output rld_bus_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic rx_irq
);
  localparam int AW = $clog2(FIFO_DEPTH);
  // ==========================================================
  // Elaboration checks
  if (FIFO_DEPTH <= 64 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two above 64");
  end
  typedef enum logic [3:0] {
    S_IDLE, S_POLL1, S_POLL0, S_DISC, S_WAIT, S_LOOK1, S_LOOK0, S_DATA, S_WB
  } rld_state_e;
  rld_state_e st_q;
  logic run_q, lae_q, receive_interrupt_flag_q, buffer_shortfall_error_q, miss_q, irq_q;
  logic [31:0] base_q;
  logic [7:0] len_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic req_q;
  rld_bus_s cmd_q;
  logic [7:0] idx_q, cur_idx_q, nxt_idx_q;
  logic [31:0] cur_addr_q, nxt_addr_q;
  logic [11:0] cur_left_q, cur_size_q, cur_cnt_q, nxt_size_q;
  logic cur_first_q, nxt_own_q, retry_q;
  logic wb_last_q, wb_err_q;
  rld_desc_s fl_q;
  logic ours_q, byte_v_q;
  logic ev_receive_interrupt_flag_q, ev_buffer_shortfall_error_q;
  logic [AW:0] wr_ptr_q, rd_ptr_q;
  logic in_frame_q, rx_done_q, rx_bad_q;
  logic [11:0] rx_cnt_q;
  logic [7:0] ram_q;
  // ==========================================================
  // Register bus decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_q & pwrite;
  wire hit_ctrl = paddr == REG_CTRL;
  wire hit_feat = paddr == REG_FEAT;
  wire hit_base = paddr == REG_BASE;
  wire hit_len = paddr == REG_LEN;
  wire hit_stat = paddr == REG_STAT;
  wire mapped = hit_ctrl | hit_feat | hit_base | hit_len | hit_stat;
  wire [31:0] ctrl_rd = {28'h0, miss_q, buffer_shortfall_error_q, receive_interrupt_flag_q, run_q};
  wire [31:0] feat_rd = {26'h0, lae_q, 5'h0};
  wire [31:0] stat_rd = {16'h0, 3'h0, nxt_own_q, 3'h0, ours_q, idx_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_feat ? feat_rd :
                       hit_base ? base_q :
                       hit_len ? {24'h0, len_q} :
                       hit_stat ? stat_rd : 32'h0;
  wire w_ctrl = apb_wr & hit_ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~mapped;
      prdata_q <= apb_setup ? rd_mux : 32'h0;
    end
  end
  // ==========================================================
  // Control and flags; a hardware set wins over a clear
  wire rx_first = rx_in.valid & ~in_frame_q;
  wire first_take = rx_first & (st_q == S_WAIT) & ~ours_q;
  wire ev_miss = rx_first & ~first_take;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      lae_q <= 1'b0;
      base_q <= BASE_RST;
      len_q <= LEN_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) run_q <= pwdata[CTRL_RUN];
      if (hit_feat) lae_q <= pwdata[FEAT_LAE];
      if (hit_base) base_q <= pwdata;
      if (hit_len) len_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_interrupt_flag_q <= 1'b0;
      buffer_shortfall_error_q <= 1'b0;
      miss_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      receive_interrupt_flag_q <= ev_receive_interrupt_flag_q | (receive_interrupt_flag_q & ~(w_ctrl & pwdata[CTRL_RECEIVE_INTERRUPT_FLAG]));
      buffer_shortfall_error_q <= ev_buffer_shortfall_error_q | (buffer_shortfall_error_q & ~(w_ctrl & pwdata[CTRL_BUFFER_SHORTFALL_ERROR]));
      miss_q <= ev_miss | (miss_q & ~(w_ctrl & pwdata[CTRL_MISS]));
      irq_q <= receive_interrupt_flag_q;
    end
  end
  // ==========================================================
  // Network side: frames are taken only when a descriptor waits
  wire [AW:0] fifo_lvl = wr_ptr_q - rd_ptr_q;
  wire fifo_empty = fifo_lvl == '0;
  wire fifo_full = fifo_lvl[AW];
  wire rx_keep = in_frame_q ? ours_q & ~rx_bad_q : first_take;
  wire rx_take = rx_in.valid & rx_keep;
  wire ram_we = rx_take & ~fifo_full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_q <= 1'b0;
      wr_ptr_q <= '0;
      rx_cnt_q <= 12'h0;
      rx_done_q <= 1'b0;
      rx_bad_q <= 1'b0;
    end else begin
      if (rx_in.valid) in_frame_q <= ~rx_in.last;
      if (ram_we) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (first_take) begin
        rx_cnt_q <= 12'h1;
        rx_done_q <= rx_in.last;
        rx_bad_q <= rx_in.err;
      end else if (rx_take) begin
        rx_cnt_q <= rx_cnt_q + 12'h1;
        rx_done_q <= rx_in.last;
        rx_bad_q <= rx_in.err | fifo_full;
      end
    end
  end
  wire ram_re = (st_q == S_DATA) & ~req_q & ~byte_v_q & ~fifo_empty;
  rld_ram #(
    .DW(8),
    .DEPTH(FIFO_DEPTH)
  ) u_ram (
    .clk(pclk),
    .rst_n(presetn),
    .we(ram_we),
    .waddr(wr_ptr_q[AW-1:0]),
    .wdata(rx_in.data),
    .re(ram_re),
    .raddr(rd_ptr_q[AW-1:0]),
    .rdata(ram_q)
  );
  // ==========================================================
  // Ring walk helpers
  function automatic logic [7:0] nx(input logic [7:0] i);
    nx = (i >= len_q - 8'h01) ? 8'h00 : i + 8'h01;
  endfunction
  function automatic logic [31:0] dsc(input logic [7:0] i);
    dsc = base_q + ({24'h0, i} << DESC_STRIDE_SH);
  endfunction
  wire rld_desc_s rd_desc = mem_rdata;
  wire ack = req_q & mem_ack;
  wire start_ok = ours_q & ((rx_cnt_q >= LOOK_THRESH) | rx_done_q |
                  rx_bad_q);
  wire drained = rx_done_q & fifo_empty & ~byte_v_q;
  wire rld_desc_s wb_word = '{own: 1'b0, err: wb_err_q, rsv: 4'h0,
                              frame_start_flag: cur_first_q, frame_end_flag: ~wb_err_q,
                              cnt: cur_cnt_q, size: cur_size_q};
  wire [31:0] wb_data = wb_last_q ? wb_word : {wb_word[31:25], 1'b0,
                        wb_word[23:0]};
  // ==========================================================
  // Descriptor and data engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      req_q <= 1'b0;
      cmd_q <= '0;
      idx_q <= 8'h0;
      cur_idx_q <= 8'h0;
      nxt_idx_q <= 8'h0;
      cur_addr_q <= 32'h0;
      nxt_addr_q <= 32'h0;
      cur_left_q <= 12'h0;
      cur_size_q <= 12'h0;
      cur_cnt_q <= 12'h0;
      nxt_size_q <= 12'h0;
      cur_first_q <= 1'b0;
      nxt_own_q <= 1'b0;
      retry_q <= 1'b0;
      wb_last_q <= 1'b0;
      wb_err_q <= 1'b0;
      fl_q <= '0;
      ours_q <= 1'b0;
      byte_v_q <= 1'b0;
      rd_ptr_q <= '0;
      ev_receive_interrupt_flag_q <= 1'b0;
      ev_buffer_shortfall_error_q <= 1'b0;
    end else begin
      ev_receive_interrupt_flag_q <= 1'b0;
      ev_buffer_shortfall_error_q <= 1'b0;
      if (ack) req_q <= 1'b0;
      if (first_take) ours_q <= 1'b1;
      if (ram_re) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        byte_v_q <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
          if (run_q) st_q <= S_POLL1;
        end
        S_POLL1: begin
          if (!req_q && !run_q) begin
            st_q <= S_IDLE;
          end else if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b0, addr: dsc(idx_q) + DESC_FLAGS_OFS,
                       wdata: 32'h0, be: 4'hf};
          end else if (ack) begin
            fl_q <= rd_desc;
            if (rd_desc.own && (rd_desc.frame_start_flag || !lae_q)) begin
              st_q <= S_POLL0;
            end else if (rd_desc.own) begin
              st_q <= S_DISC;
            end else if (lae_q && !rd_desc.frame_start_flag) begin
              idx_q <= nx(idx_q);
            end
          end
        end
        S_DISC: begin
          if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b1, addr: dsc(idx_q) + DESC_FLAGS_OFS,
                       wdata: {1'b0, fl_q[30:0]}, be: 4'hf};
          end else if (ack) begin
            idx_q <= nx(idx_q);
            st_q <= S_POLL1;
          end
        end
        S_POLL0: begin
          if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b0, addr: dsc(idx_q), wdata: 32'h0,
                       be: 4'hf};
          end else if (ack) begin
            cur_addr_q <= mem_rdata;
            cur_left_q <= fl_q.size;
            cur_size_q <= fl_q.size;
            cur_cnt_q <= 12'h0;
            cur_first_q <= 1'b1;
            cur_idx_q <= idx_q;
            nxt_idx_q <= nx(idx_q);
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (start_ok) begin
            nxt_own_q <= 1'b0;
            retry_q <= 1'b0;
            st_q <= S_LOOK1;
          end
        end
        S_LOOK1: begin
          if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b0, addr: dsc(nxt_idx_q) + DESC_FLAGS_OFS,
                       wdata: 32'h0, be: 4'hf};
          end else if (ack) begin
            nxt_own_q <= rd_desc.own;
            nxt_size_q <= rd_desc.size;
            if (rd_desc.own) begin
              st_q <= S_LOOK0;
            end else if (retry_q) begin
              wb_last_q <= 1'b1;
              wb_err_q <= 1'b1;
              ev_buffer_shortfall_error_q <= 1'b1;
              st_q <= S_WB;
            end else begin
              st_q <= S_DATA;
            end
          end
        end
        S_LOOK0: begin
          if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b0, addr: dsc(nxt_idx_q), wdata: 32'h0,
                       be: 4'hf};
          end else if (ack) begin
            nxt_addr_q <= mem_rdata;
            st_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (req_q) begin
            if (ack) begin
              cur_addr_q <= cur_addr_q + 32'h1;
              cur_left_q <= cur_left_q - 12'h1;
              cur_cnt_q <= cur_cnt_q + 12'h1;
              byte_v_q <= 1'b0;
            end
          end else if (rx_bad_q) begin
            wb_last_q <= 1'b1;
            wb_err_q <= 1'b1;
            st_q <= S_WB;
          end else if (drained) begin
            wb_last_q <= 1'b1;
            wb_err_q <= 1'b0;
            st_q <= S_WB;
          end else if (byte_v_q && cur_left_q == 12'h0) begin
            wb_last_q <= 1'b0;
            wb_err_q <= 1'b0;
            if (nxt_own_q) begin
              st_q <= S_WB;
            end else begin
              retry_q <= 1'b1;
              st_q <= S_LOOK1;
            end
          end else if (byte_v_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b1, addr: cur_addr_q, wdata: {4{ram_q}},
                       be: 4'h1 << cur_addr_q[1:0]};
          end
        end
        S_WB: begin
          if (!req_q) begin
            req_q <= 1'b1;
            cmd_q <= '{we: 1'b1, addr: dsc(cur_idx_q) + DESC_FLAGS_OFS,
                       wdata: wb_data, be: 4'hf};
          end else if (ack) begin
            // Early flag only in look-ahead mode; completion always
            ev_receive_interrupt_flag_q <= wb_last_q | (cur_first_q & lae_q);
            if (wb_last_q) begin
              ours_q <= first_take;
              byte_v_q <= 1'b0;
              rd_ptr_q <= wr_ptr_q;
              idx_q <= nx(cur_idx_q);
              st_q <= S_POLL1;
            end else begin
              cur_idx_q <= nxt_idx_q;
              cur_addr_q <= nxt_addr_q;
              cur_left_q <= nxt_size_q;
              cur_size_q <= nxt_size_q;
              cur_cnt_q <= 12'h0;
              cur_first_q <= 1'b0;
              nxt_idx_q <= nx(nxt_idx_q);
              nxt_own_q <= 1'b0;
              retry_q <= 1'b0;
              st_q <= S_LOOK1;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_req = req_q;
  assign mem_cmd = cmd_q;
  assign rx_irq = irq_q;
endmodule // rld_dma
`default_nettype wire

// ==== rld_dma_properties.sv ====
// Port checker for the receive look-ahead DMA block
`timescale 1ns/10ps
`default_nettype none
module rld_dma_properties
  import rld_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rld_rx_s rx_in,
  input wire logic mem_req,
  input wire rld_bus_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rx_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Helpers
  logic mapped;
  logic flag_wr;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= REG_STAT;
  assign flag_wr = mem_req && mem_ack && mem_cmd.we && mem_cmd.addr[2] &&
    mem_cmd.be == 4'hf;
  // ==========
  // Assertions
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("slave error wrong");
  req_hold_a: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_cmd))
    else $error("request dropped or changed");
  req_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("no gap after ack");
  byte_lane_a: assert property (
    mem_req && mem_cmd.we && mem_cmd.be != 4'hf
    |-> mem_cmd.be == 4'h1 << mem_cmd.addr[1:0] &&
    mem_cmd.wdata == {4{mem_cmd.wdata[7:0]}})
    else $error("byte lane wrong");
  read_word_a: assert property (
    mem_req && !mem_cmd.we |-> mem_cmd.be == 4'hf)
    else $error("partial read");
  end_irq_a: assert property (flag_wr && !mem_cmd.wdata[31] &&
    mem_cmd.wdata[24] |-> ##[1:3] rx_irq)
    else $error("no interrupt after final write");
  irq_cause_a: assert property ($rose(rx_irq) |->
    $past(flag_wr, 1) || $past(flag_wr, 2) || $past(flag_wr, 3))
    else $error("interrupt without descriptor write");
  cover property ($rose(rx_irq));
  cover property (flag_wr && mem_cmd.wdata[30]);
  cover property (pready && pslverr);
endmodule // rld_dma_properties
bind rld_dma rld_dma_properties rld_dma_properties_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .rx_in, .mem_req, .mem_cmd, .mem_ack, .mem_rdata,
  .rx_irq
);
`default_nettype wire

// ==== rld_dma_tb.sv ====
// Self-checking bench for the receive look-ahead DMA block
`timescale 1ns/10ps
`default_nettype none
module rld_dma_tb
  import rld_pkg::*;
  ;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, mem_req, mem_ack, rx_irq, slv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, rd;
  rld_rx_s rx_in = '0;
  rld_bus_s mem_cmd;
  int error_cnt = 0, checks = 0, sent = 0;
  initial forever #5 pclk = ~pclk;
  rld_dma rld_dma_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_in, .mem_req, .mem_cmd, .mem_ack, .mem_rdata,
    .rx_irq
  );
  rld_mem_model rld_mem_model_i (
    .pclk, .presetn, .mem_req, .mem_cmd, .mem_ack, .mem_rdata
  );
  // Set once the block has fetched the address word of a descriptor
  logic latched;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) latched <= 1'b0;
    else if (mem_ack && !mem_cmd.we && !mem_cmd.addr[2]) latched <= 1'b1;
  end
  // ==========
  // Shared tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] d(input int i);
    return rld_mem_model_i.mem[2 * i + 1];
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) fail("apb hang");
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Driver-side descriptor set-up, flags word own/stp/size
  task automatic desc(input int i, input int p, input logic o, s, input int z);
    @(negedge pclk);
    rld_mem_model_i.mem[2 * i] = 32'(p);
    rld_mem_model_i.mem[2 * i + 1] = {o, 5'h0, s, 13'h0, z[11:0]};
  endtask
  task automatic start(input logic la, input logic [7:0] len, input int lt);
    rld_mem_model_i.lat = lt;
    // Old buffer contents would let a missing data write pass
    for (int i = 32; i < 256; i++) rld_mem_model_i.mem[i] = 32'h0;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, REG_FEAT, {26'h0, la, 5'h0});
    apb(1'b1, REG_LEN, {24'h0, len});
    apb(1'b1, REG_CTRL, 32'h1);
  endtask
  // Frames are only sent once a descriptor is latched, else they drop
  task automatic frame(input int len);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
      if (n > 100) fail("no descriptor");
    end while (latched !== 1'b1);
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      rx_in <= '{1'b1, i[7:0], i == len - 1, 1'b0};
      sent = i + 1;
    end
    @(posedge pclk);
    rx_in <= '0;
  endtask
  // Negative index waits for the interrupt, else for the owner bit to clear
  task automatic wait_on(input int i);
    int n;
    n = 0;
    while (i < 0 ? rx_irq !== 1'b1 :
        rld_mem_model_i.mem[2 * i + 1][31] !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > 4000) fail("no hand-back");
    end
  endtask
  task automatic chk_data(input int p, f, n);
    logic [31:0] w;
    for (int k = 0; k < n; k++) begin
      w = rld_mem_model_i.mem[(p + k) / 4];
      chk({24'h0, w[8 * ((p + k) % 4) +: 8]}, 32'((f + k) % 256));
    end
  endtask
  always @(posedge pclk) begin
    if (mem_ack && mem_cmd.we && mem_cmd.be != 4'hf && rx_in.valid &&
        sent < 64) fail("data moved early");
  end
  // ==========
  // Scenarios
  task automatic t_look_ahead_packet_processing();
    desc(0, 'h100, 1'b1, 1'b1, 80);
    desc(1, 'h180, 1'b1, 1'b0, 16);
    desc(2, 'h0, 1'b0, 1'b0, 32);
    start(1'b1, 8'h3, 0);
    apb(1'b0, 8'h20, 32'h0);
    chk({slv, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, REG_BASE, 32'h0);
    chk(rd, BASE_RST);
    frame(110);
    wait_on(-1);
    chk(d(0), 32'h0205_0050);
    desc(2, 'h200, 1'b1, 1'b0, 32);
    wait_on(2);
    chk(d(1), 32'h0001_0010);
    chk(d(2), 32'h0100_e020);
    chk_data('h100, 0, 80);
    chk_data('h180, 80, 16);
    chk_data('h200, 96, 14);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd & 32'hff, 32'h0);
    $display("look-ahead three buffer test done");
  endtask
  task automatic t_buffer_shortfall_error();
    desc(0, 'h100, 1'b1, 1'b1, 64);
    desc(1, 'h180, 1'b0, 1'b0, 16);
    start(1'b1, 8'h2, 1);
    frame(100);
    wait_on(0);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd & 32'h4, 32'h4);
    chk(d(0) & 32'hc000_0000, 32'h4000_0000);
    chk_data('h100, 0, 64);
    $display("buffer shortfall test done");
  endtask
  task automatic t_nola();
    desc(0, 'h100, 1'b1, 1'b1, 32);
    desc(1, 'h180, 1'b1, 1'b0, 64);
    start(1'b0, 8'h2, 3);
    frame(40);
    wait_on(-1);
    chk(d(1), 32'h0100_8040);
    chk(d(0), 32'h0202_0020);
    chk_data('h180, 32, 8);
    $display("look-ahead off test done");
  endtask
  task automatic t_skip();
    desc(0, 'h100, 1'b1, 1'b0, 16);
    desc(1, 'h180, 1'b0, 1'b0, 16);
    desc(2, 'h200, 1'b1, 1'b1, 64);
    desc(3, 'h280, 1'b0, 1'b0, 16);
    start(1'b1, 8'h4, 0);
    frame(20);
    wait_on(2);
    chk(d(0) & 32'h8000_0000, 32'h0);
    chk(d(1), 32'h0000_0010);
    chk(d(2), 32'h0301_4040);
    $display("descriptor skip test done");
  endtask
  initial begin
    t_look_ahead_packet_processing();
    t_buffer_shortfall_error();
    t_nola();
    t_skip();
    end_of_test();
  end
endmodule // rld_dma_tb
`default_nettype wire

// ==== rld_mem_model.sv ====
// Host memory model answering the DMA block's bus requests
`timescale 1ns/10ps
`default_nettype none
module rld_mem_model
  import rld_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire rld_bus_s mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ==========
  // Store and answer, lat sets the wait
  logic [31:0] mem [0:255];
  logic [7:0] wi;
  int lat = 0;
  int wait_q = 0;
  assign wi = mem_cmd.addr[9:2];
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q <= 0;
    end else if (mem_req && !mem_ack && wait_q < lat) begin
      wait_q <= wait_q + 1;
    end else if (mem_req && !mem_ack) begin
      wait_q <= 0;
      mem_ack <= 1'b1;
      mem_rdata <= mem[wi];
      for (int b = 0; b < 4; b++) begin
        if (mem_cmd.we && mem_cmd.be[b]) begin
          mem[wi][8*b +: 8] <= mem_cmd.wdata[8*b +: 8];
        end
      end
    end else begin
      // Released lines must not keep showing the last word
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // rld_mem_model
`default_nettype wire

// ==== rld_pkg.sv ====
// Constants and types shared by the receive look-ahead DMA block
package rld_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FEAT = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_LEN = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  // ==========================================================
  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RECEIVE_INTERRUPT_FLAG = 1;
  localparam int CTRL_BUFFER_SHORTFALL_ERROR = 2;
  localparam int CTRL_MISS = 3;
  localparam int FEAT_LAE = 5;
  // ==========================================================
  // Reset values, start threshold and descriptor layout
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [11:0] LOOK_THRESH = 12'h040;
  localparam logic [31:0] DESC_STRIDE_SH = 32'h0000_0003;
  localparam logic [31:0] DESC_FLAGS_OFS = 32'h0000_0004;
  // ==========================================================
  // Types
  typedef struct packed {
    logic own;
    logic err;
    logic [3:0] rsv;
    logic frame_start_flag;
    logic frame_end_flag;
    logic [11:0] cnt;
    logic [11:0] size;
  } rld_desc_s;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } rld_bus_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic err;
  } rld_rx_s;
endpackage

// ==== rld_ram.sv ====
// Byte store for frame data held before it reaches host memory
`timescale 1ns/10ps
`default_nettype none
module rld_ram #(
  parameter int DW = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the store mappable to block RAM
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;
endmodule // rld_ram
`default_nettype wire
